// file: logic/ccpll_ctrl.sv
// top: clock source selection, pll control, start-up sequencing, apb registers
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ccpll_ctrl import ccpll_pkg::*; #(
  parameter int WDT_LONG = WDT_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [3:0] clock_source_fuses_i,
  input wire logic [1:0] startup_time_fuses_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire logic wdt_osc_i,
  output logic rc_osc_enable_o,
  output logic rc_reduced_o,
  output logic [7:0] rc_trim_o,
  output logic pll_enable_o,
  output logic pll_half_src_o,
  output logic [3:0] pll_mult_o,
  output logic pll_lock_flag_o,
  output logic [2:0] sys_src_o,
  output logic sys_div4_o,
  output logic fuse_reserved_o,
  output logic cpu_run_o,
  output logic timer_pck_sel_o,
  output logic timer_pck_div_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ST_BOOT, ST_RST_CK, ST_RST_WDT, ST_RUN, ST_SLEEP, ST_WAKE} ccpll_st_t;

  typedef struct packed {
    ccpll_st_t st;
    logic [CNT_W-1:0] cnt;
    logic wdt_prev;
    logic [3:0] clock_source_fuses;
    logic [1:0] startup_time_fuses;
    logic pll_en_bit;
    logic low_speed_select;
    logic tpck;
    logic tdiv;
    logic lock;
    logic [7:0] lock_cnt;
    logic [7:0] trim;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic rc_on;
    logic rc_red;
    logic pll_on;
    logic half;
    logic [3:0] mult;
    ccpll_src_t src;
    logic div4;
    logic rsv;
    logic run;
  } ccpll_state_t;

  ccpll_state_t s_q;
  ccpll_state_t s_d;
  ccpll_fuse_if f ();
  logic wdt_lvl;

  ccpll_sync3 u_wdt_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(wdt_osc_i),
    .q_o(wdt_lvl)
  );

  ccpll_fuse_dec u_dec (
    .f(f)
  );

  assign f.clock_source_fuses = s_q.clock_source_fuses;
  assign f.startup_time_fuses = s_q.startup_time_fuses;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] a);
    return (a == OFF_PLL_CS) || (a == OFF_TRIM) || (a == OFF_STAT);
  endfunction

  function automatic logic [CNT_W-1:0] wdt_last(input logic [1:0] startup_time_fuses);
    if (startup_time_fuses == SUT_SHORT) begin
      return CNT_W'(WDT_SHORT_CYC - 1);
    end
    return CNT_W'(WDT_LONG - 1);
  endfunction

  logic setup;
  logic wr_acc;
  logic cfg;
  logic wdt_edge;
  logic lsm_block;
  logic [31:0] rdata;

  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && s_q.pready && pwrite_i;
  assign cfg = (s_q.st != ST_BOOT);
  assign wdt_edge = wdt_lvl && !s_q.wdt_prev;
  assign lsm_block = (f.src == SRC_PLL) || f.compat;

  always_comb begin
    rdata = '0;
    unique case (paddr_i)
      OFF_PLL_CS: begin
        rdata[CS_LOCK] = s_q.lock;
        rdata[CS_PLL_ENABLE_BIT] = s_q.pll_en_bit;
        rdata[CS_LSM] = s_q.low_speed_select;
        rdata[CS_TPCK] = s_q.tpck;
        rdata[CS_TDIV] = s_q.tdiv;
      end
      OFF_TRIM: begin
        rdata[7:0] = s_q.trim;
      end
      OFF_STAT: begin
        rdata[SB_SRC +: 3] = s_q.src;
        rdata[SB_FRSV] = s_q.rsv;
        rdata[SB_SRSV] = f.sut_rsv;
        rdata[SB_COMPAT] = s_q.rc_red;
        rdata[SB_PLLON] = s_q.pll_on;
        rdata[SB_RUN] = s_q.run;
        rdata[SB_CLOCK_SOURCE_FUSES +: 4] = s_q.clock_source_fuses;
      end
      default: begin
        rdata = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.wdt_prev = wdt_lvl;
    unique case (s_q.st)
      ST_BOOT: begin
        // fuses caught once, after reset release
        s_d.clock_source_fuses = clock_source_fuses_i;
        s_d.startup_time_fuses = startup_time_fuses_i;
        s_d.cnt = '0;
        s_d.st = ST_RST_CK;
      end
      ST_RST_CK: begin
        if (s_q.cnt == CNT_W'(RESET_CK - 1)) begin
          s_d.cnt = '0;
          s_d.st = (s_q.startup_time_fuses == SUT_NONE) ? ST_RUN : ST_RST_WDT;
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      ST_RST_WDT: begin
        if (wdt_edge) begin
          if (s_q.cnt == wdt_last(s_q.startup_time_fuses)) begin
            s_d.cnt = '0;
            s_d.st = ST_RUN;
          end else begin
            s_d.cnt = s_q.cnt + CNT_W'(1);
          end
        end
      end
      ST_RUN: begin
        if (sleep_i) begin
          s_d.st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_i) begin
          s_d.cnt = '0;
          s_d.st = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (s_q.cnt == CNT_W'(WAKE_CK - 1)) begin
          s_d.cnt = '0;
          s_d.st = ST_RUN;
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
    endcase

    // lock detect; a trim above nominal saturates the pll out of lock
    if (!s_q.pll_on || (s_q.trim > TRIM_NOM)) begin
      s_d.lock = 1'b0;
      s_d.lock_cnt = '0;
    end else if (s_q.lock_cnt == 8'(PLL_LOCK_CYC - 1)) begin
      s_d.lock = 1'b1;
    end else begin
      s_d.lock_cnt = s_q.lock_cnt + 8'h01;
    end

    // apb slave, answer in the first access cycle
    s_d.pready = setup;
    s_d.pslverr = setup && !reg_hit(paddr_i);
    s_d.prdata = (setup && !pwrite_i) ? rdata : '0;
    if (wr_acc && (paddr_i == OFF_PLL_CS)) begin
      s_d.pll_en_bit = pwdata_i[CS_PLL_ENABLE_BIT];
      s_d.low_speed_select = pwdata_i[CS_LSM] && !lsm_block;
      s_d.tpck = pwdata_i[CS_TPCK];
      s_d.tdiv = pwdata_i[CS_TDIV];
    end
    if (wr_acc && (paddr_i == OFF_TRIM)) begin
      s_d.trim = pwdata_i[7:0];
    end

    // clock tree controls
    s_d.rc_on = (s_q.st != ST_SLEEP);
    s_d.pll_on = (s_q.pll_en_bit || (cfg && f.pll_force)) && (s_q.st != ST_SLEEP);
    s_d.rc_red = cfg && f.compat;
    s_d.half = s_q.low_speed_select && !f.compat;
    s_d.mult = (cfg && f.compat) ? PLL_MUL_COMPAT : PLL_MUL_NORM;
    s_d.src = cfg ? f.src : SRC_EXT;
    s_d.div4 = cfg && f.div4;
    s_d.rsv = cfg && f.rsv;
    s_d.run = (s_q.st == ST_RUN);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.trim <= TRIM_RST;
      s_q.rc_on <= 1'b1;
      s_q.mult <= PLL_MUL_NORM;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign rc_osc_enable_o = s_q.rc_on;
  assign rc_reduced_o = s_q.rc_red;
  assign rc_trim_o = s_q.trim;
  assign pll_enable_o = s_q.pll_on;
  assign pll_half_src_o = s_q.half;
  assign pll_mult_o = s_q.mult;
  assign pll_lock_flag_o = s_q.lock;
  assign sys_src_o = s_q.src;
  assign sys_div4_o = s_q.div4;
  assign fuse_reserved_o = s_q.rsv;
  assign cpu_run_o = s_q.run;
  assign timer_pck_sel_o = s_q.tpck;
  assign timer_pck_div_o = s_q.tdiv;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_PLL_ENABLE: assert property (
    (s_q.st != ST_SLEEP && (s_q.pll_en_bit || (cfg && f.pll_force))) |=> pll_enable_o
  ) else $error("pll not enabled although requested");

  AST_SLEEP_OFF: assert property (
    (s_q.st == ST_SLEEP) |=> (!pll_enable_o && !rc_osc_enable_o)
  ) else $error("oscillator or pll running in sleep");

  AST_LOCK_CLEAR: assert property (
    !pll_enable_o |=> !pll_lock_flag_o
  ) else $error("lock flag set with pll off");

  AST_LOCK_RISE: assert property (
    $rose(pll_lock_flag_o) |-> ($past(pll_enable_o) && $past(pll_enable_o, 2))
  ) else $error("lock flag rose without a running pll");

  AST_LSM_BLOCK: assert property (
    (wr_acc && paddr_i == OFF_PLL_CS && f.src == SRC_PLL && !s_q.low_speed_select) |=> !s_q.low_speed_select
  ) else $error("low speed set while pll clocks system");

  AST_COMPAT: assert property (
    (cfg && f.compat) |=> (pll_mult_o == PLL_MUL_COMPAT && rc_reduced_o && !pll_half_src_o)
  ) else $error("compatibility mode settings wrong");

  AST_DIV4: assert property (
    (cfg && (f.compat || f.src == SRC_PLL)) |=> sys_div4_o
  ) else $error("system clock not divided by four");

  AST_HALF_SRC: assert property (
    (s_q.low_speed_select && !f.compat) |=> pll_half_src_o
  ) else $error("pll source not halved");

  AST_WAKE_DELAY: assert property (
    (s_q.st == ST_SLEEP && wake_i) |=> !cpu_run_o [*7] ##1 cpu_run_o
  ) else $error("wake start-up delay wrong");

  AST_RESET_CK: assert property (
    (s_q.st == ST_RST_CK && s_q.cnt == CNT_W'(RESET_CK - 1) && s_q.startup_time_fuses == SUT_NONE) |=> s_q.st == ST_RUN
  ) else $error("reset delay without time-out wrong");

  AST_TRIM: assert property (
    (wr_acc && paddr_i == OFF_TRIM) |=> (rc_trim_o == $past(pwdata_i[7:0]))
  ) else $error("trim not applied");

  COV_WAKE: cover property (s_q.st == ST_WAKE ##[1:10] cpu_run_o);
  COV_LOCK: cover property ($rose(pll_lock_flag_o));
  COV_WDT_DONE: cover property (s_q.st == ST_RST_WDT ##1 s_q.st == ST_RUN);
  COV_ERR: cover property (pslverr_o && pready_o);
endmodule // ccpll_ctrl
`default_nettype wire

// file: logic/ccpll_fuse_dec.sv
// fuse decoder: clock source, compatibility mode and reserved codes
`timescale 1ns/1ps
`default_nettype none
module ccpll_fuse_dec import ccpll_pkg::*; (
  ccpll_fuse_if.dec f
);
  // cells read 1 when unprogrammed, so the stored pattern is the code
  function automatic ccpll_src_t src_of(input logic [3:0] c);
    if (c[CK_XTAL_BIT]) begin
      return SRC_XTAL;
    end
    unique case (c)
      CK_EXT: return SRC_EXT;
      CK_PLL: return SRC_PLL;
      CK_RC, CK_COMPAT: return SRC_RC;
      CK_LP: return SRC_LP;
      CK_LFX: return SRC_LFX;
      default: return SRC_RSV;
    endcase
  endfunction

  always_comb begin
    f.src = src_of(f.clock_source_fuses);
    f.rsv = (src_of(f.clock_source_fuses) == SRC_RSV);
    f.compat = (f.clock_source_fuses == CK_COMPAT);
    f.pll_force = (f.clock_source_fuses == CK_PLL) || (f.clock_source_fuses == CK_COMPAT);
    f.div4 = f.pll_force;
    f.sut_rsv = (f.startup_time_fuses == SUT_RSV);
  end
endmodule // ccpll_fuse_dec
`default_nettype wire

// file: logic/ccpll_sync3.sv
// three-stage synchroniser, output moves when the last two stages agree
`timescale 1ns/1ps
`default_nettype none
module ccpll_sync3 (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic [2:0] sh;
    logic q;
  } ccpll_sync_t;
  ccpll_sync_t s_q;
  ccpll_sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[1:0], d_i};
    if (s_q.sh[1] == s_q.sh[2]) begin
      s_d.q = s_q.sh[2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.q;
endmodule // ccpll_sync3
`default_nettype wire

// file: shared/ccpll_fuse_if.sv
// interface: captured fuse values and their decoded meaning
`timescale 1ns/1ps
`default_nettype none
interface ccpll_fuse_if import ccpll_pkg::*; ();
  logic [3:0] clock_source_fuses;
  logic [1:0] startup_time_fuses;
  ccpll_src_t src;
  logic rsv;
  logic sut_rsv;
  logic compat;
  logic pll_force;
  logic div4;
  modport dec (input clock_source_fuses, startup_time_fuses, output src, rsv, sut_rsv, compat, pll_force, div4);
  modport ctl (output clock_source_fuses, startup_time_fuses, input src, rsv, sut_rsv, compat, pll_force, div4);
endinterface
`default_nettype wire

// file: shared/ccpll_pkg.sv
// package: constants and types of the clock source and pll control block
package ccpll_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_PLL_CS = 12'h000;
  localparam logic [11:0] OFF_TRIM = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam int CS_LOCK = 0;
  localparam int CS_PLL_ENABLE_BIT = 1;
  localparam int CS_LSM = 2;
  localparam int CS_TPCK = 3;
  localparam int CS_TDIV = 4;
  localparam int SB_SRC = 0;
  localparam int SB_FRSV = 3;
  localparam int SB_SRSV = 4;
  localparam int SB_COMPAT = 5;
  localparam int SB_PLLON = 6;
  localparam int SB_RUN = 7;
  localparam int SB_CLOCK_SOURCE_FUSES = 8;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [7:0] TRIM_NOM = 8'h80;
  // ---------------------------------------------------------------
  // fuse codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CK_EXT = 4'h0;
  localparam logic [3:0] CK_PLL = 4'h1;
  localparam logic [3:0] CK_RC = 4'h2;
  localparam logic [3:0] CK_COMPAT = 4'h3;
  localparam logic [3:0] CK_LP = 4'h4;
  localparam logic [3:0] CK_LFX = 4'h6;
  localparam int CK_XTAL_BIT = 3;
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG = 2'h2;
  localparam logic [1:0] SUT_RSV = 2'h3;
  localparam logic [3:0] PLL_MUL_NORM = 4'h8;
  localparam logic [3:0] PLL_MUL_COMPAT = 4'h4;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int CNT_W = 14;
  localparam int WAKE_CK = 6;
  localparam int RESET_CK = 14;
  localparam int WDT_SHORT_CYC = 512;
  localparam int WDT_LONG_CYC = 8192;
  localparam int PLL_LOCK_NS = 1000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {SRC_EXT, SRC_PLL, SRC_RC, SRC_LP, SRC_LFX, SRC_XTAL, SRC_RSV} ccpll_src_t;
endpackage

// file: tb/ccpll_ctrl_test.sv
// self-checking testbench of the clock source and pll control block
`timescale 1ns/1ps
`default_nettype none
module ccpll_ctrl_test import ccpll_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] clock_source_fuses_i = 4'h2;
  logic [1:0] startup_time_fuses_i = 2'h0;
  logic sleep_i = 1'b0;
  logic wake_i = 1'b0;
  logic wdt_osc_i;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rc_osc_enable_o, rc_reduced_o, pll_enable_o, pll_half_src_o;
  logic pll_lock_flag_o, sys_div4_o, fuse_reserved_o, cpu_run_o, timer_pck_sel_o, timer_pck_div_o;
  logic [7:0] rc_trim_o;
  logic [3:0] pll_mult_o;
  logic [2:0] sys_src_o;
  logic [31:0] rd, st;
  logic err;
  logic [7:0] rnd = 8'h31;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int wc = 0;

  ccpll_ctrl #(.WDT_LONG(16)) uut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .clock_source_fuses_i, .startup_time_fuses_i, .sleep_i, .wake_i,
    .wdt_osc_i, .rc_osc_enable_o, .rc_reduced_o, .rc_trim_o, .pll_enable_o, .pll_half_src_o, .pll_mult_o,
    .pll_lock_flag_o, .sys_src_o, .sys_div4_o, .fuse_reserved_o, .cpu_run_o, .timer_pck_sel_o,
    .timer_pck_div_o);
  ccpll_wdt_model wdt (.osc_o(wdt_osc_i));

  // steady clock, no step in frequency while out of reset
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [2:0] exp_src(input logic [3:0] f);
    if (f[3]) return 3'h5;
    case (f)
      4'h0: return 3'h0;
      4'h1: return 3'h1;
      4'h2, 4'h3: return 3'h2;
      4'h4: return 3'h3;
      4'h6: return 3'h4;
      default: return 3'h6;
    endcase
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    #1;
    while (pready_o !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // answer stands until the next edge, where the transfer completes
    rd = prdata_o;
    err = pslverr_o;
    @(posedge clk_i);
    if (n >= 16) fail_count++;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // reset with given fuses, then time the start-up; n = watchdog edges expected
  task automatic boot(input logic [3:0] f, input logic [1:0] s, input int n);
    int c;
    int lo;
    c = 0;
    lo = 15 + (n * 1946) / 400 - (n > 0 ? 6 : 0);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    clock_source_fuses_i <= f;
    startup_time_fuses_i <= s;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    do begin
      @(posedge clk_i);
      #1;
      c++;
    end while (cpu_run_o !== 1'b1 && c < 3000);
    chk("run_delay", 32'h1, 32'(c >= lo && c <= lo + 40));
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    wt(2);
    chk("rst_out", {17'h0, 1'b1, 8'h80, 4'h8, 2'h0}, {17'h0, rc_osc_enable_o, rc_trim_o, pll_mult_o, pll_enable_o, cpu_run_o});
    for (int f = 0; f < 16; f++) begin
      boot(4'(f), 2'h0, 0);
      st = {20'h0, 4'(f), 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, exp_src(4'(f))};
      st[3] = (f == 5 || f == 7);
      st[5] = (f == 3);
      st[6] = (f == 1 || f == 3);
      apb(1'b0, OFF_STAT, 32'h0);
      chk("stat", st, rd);
      chk("src", 32'(exp_src(4'(f))), 32'(sys_src_o));
      chk("rsv", 32'(st[3]), 32'(fuse_reserved_o));
      chk("pll_on", 32'(st[6]), 32'(pll_enable_o));
      chk("mult", (f == 3) ? 32'h4 : 32'h8, 32'(pll_mult_o));
      chk("reduced", 32'(st[5]), 32'(rc_reduced_o));
      chk("div4", 32'(st[6]), 32'(sys_div4_o));
      if (f == 1 || f == 3) begin
        apb(1'b1, OFF_PLL_CS, 32'h4);
        apb(1'b0, OFF_PLL_CS, 32'h0);
        chk("lsm_blk", 32'h0, {29'h0, rd[2], 1'b0, pll_half_src_o});
      end
    end
    boot(4'h2, 2'h1, 512);
    boot(4'h2, 2'h2, 16);
    boot(4'h0, 2'h3, 16);
    apb(1'b0, OFF_TRIM, 32'h0);
    chk("trim_rst", 32'h80, rd);
    apb(1'b1, OFF_PLL_CS, 32'hffff_ff02);
    apb(1'b0, OFF_PLL_CS, 32'h0);
    chk("cs_unlocked", 32'h2, rd);
    wt(40);
    apb(1'b1, OFF_PLL_CS, 32'h6);
    apb(1'b0, OFF_PLL_CS, 32'h0);
    chk("cs_locked", 32'h7, rd);
    chk("half_src", 32'h1, 32'(pll_half_src_o));
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, OFF_TRIM, {24'h0, i == 0 ? 8'h80 : rnd & 8'h7f});
      wt(1);
      chk("trim", 32'(i == 0 ? 8'h80 : rnd & 8'h7f), 32'(rc_trim_o));
      chk("lock_kept", 32'h1, 32'(pll_lock_flag_o));
    end
    apb(1'b1, OFF_TRIM, 32'h90);
    wt(3);
    chk("lock_over", 32'h0, 32'(pll_lock_flag_o));
    apb(1'b1, OFF_TRIM, 32'h80);
    apb(1'b1, OFF_PLL_CS, 32'h1a);
    wt(40);
    chk("timer", 32'h7, {29'h0, pll_lock_flag_o, timer_pck_sel_o, timer_pck_div_o});
    apb(1'b1, OFF_PLL_CS, 32'h0);
    wt(2);
    chk("lock_off", 32'h0, {pll_enable_o, pll_lock_flag_o});
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b0, OFF_STAT, 32'h0);
    st = rd;
    chk("sut_rsv", 32'h1, {31'h0, st[4]});
    apb(1'b1, OFF_STAT, ~st);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat_ro", st, rd);
    boot(4'h1, 2'h0, 0);
    wt(40);
    @(posedge clk_i);
    sleep_i <= 1'b1;
    wt(4);
    chk("sleep", 32'h0, {rc_osc_enable_o, pll_enable_o, pll_lock_flag_o, cpu_run_o});
    @(posedge clk_i);
    sleep_i <= 1'b0;
    wt(3);
    @(posedge clk_i);
    wake_i <= 1'b1;
    wc = 0;
    do begin
      @(posedge clk_i);
      wake_i <= 1'b0;
      #1;
      wc++;
    end while (cpu_run_o !== 1'b1 && wc < 40);
    chk("wake_delay", 32'h1, 32'(wc >= 7 && wc <= 10));
    chk("wake_osc", 32'h3, {rc_osc_enable_o, pll_enable_o});
    end_sim();
  end
endmodule // ccpll_ctrl_test
`default_nettype wire

// file: tb/ccpll_wdt_model.sv
// watchdog oscillator model for the start-up time-out
`timescale 1ns/1ps
`default_nettype none
module ccpll_wdt_model #(
  parameter real HALF_NS = 97.3
) (
  output logic osc_o
);
  // free running, phase unrelated to the system clock
  initial begin
    osc_o = 1'b0;
    forever #(HALF_NS) osc_o = ~osc_o;
  end
endmodule // ccpll_wdt_model
`default_nettype wire
